// >>> bld_config_regs.sv
// How it works
// - Over-limit current blocks switching until next cycle.
// - Five consecutive 7.5A cycles latch switching off.
// - Above 140C with enable, decrement LED current.
// - Decrement enable is bit 7, reset one.
// - Shut down hot, recover below lower threshold.
// - Answer bus address 0x38 with direction bit.
// - Second byte selects the register.
// - Dimming mode bits 6:5, reset mix.
// - Bit 4 picks mix transfer point.
// - Bit 3 picks mix output frequency.
// - Bits 2:1 pick spread modulation, 11 off.
// - Bit 0 picks spread jitter range.
// - Phase shift enable, bit 7, reset zero.
// - Short threshold bits 6:5, reset 01.
// - Switching frequency bits 4:3, reset 01.
// - Active string count bits 2:0.
// - Fault flags stick until read or reset.
// - Bit 6 picks 20ms or 40ms saturation.
// - Bit 7 enables short-all-strings protection.
`include "bld_regs.svh"

module bld_config_regs
   import bld_pkg::*;
#(
   parameter int         TSAT_SHORT_CYC = `BLD_TSAT_SHORT_CYC,
   parameter int         TSAT_LONG_CYC  = `BLD_TSAT_LONG_CYC,
   // Identity byte; the default value is arbitrary.
   parameter logic [7:0] IDENTITY_BYTE  = 8'h5a
)(
   // Clock and power-on reset.
   input  wire logic    clk,
   input  wire logic    nrst,
   // Serial bus pins.
   input  wire logic    scl_i,
   input  wire logic    sda_i,
   output logic         sda_o,
   output logic         sda_oe_n,
   // Analog comparator and detector inputs.
   input  wire logic    current_limit_hit,
   input  wire logic    current_latch_hit,
   input  wire logic    temp_decrement_hit,
   input  wire logic    temp_upper_hit,
   input  wire logic    temp_lower_below,
   input  wire logic    comp_saturated,
   input  wire logic    string_open_event,
   input  wire logic    string_short_event,
   input  wire logic    output_uv_event,
   // Configuration towards the analog and dimming blocks.
   output bld_dim_cfg_t dim_cfg,
   output bld_chan_cfg_t chan_cfg,
   output logic         short_all_strings_enable,
   output logic         loop_saturation_time_select,
   // Switching and protection state.
   output logic         switch_enable,
   output logic         cycle_start,
   output logic         current_decrement,
   output logic         thermal_shutdown,
   output logic         latched_off
);

   localparam int NSYNC = 9;

   logic             rst_meta;   // First reset release stage.
   logic             rst_n;      // Released reset for the design.
   logic [NSYNC-1:0] pin_raw;    // Asynchronous inputs gathered.
   logic [NSYNC-1:0] pin_meta;   // First synchroniser stage.
   logic [NSYNC-1:0] pin_s;      // Safe copies of the inputs.
   logic             scl_meta;
   logic             sda_meta;
   logic             scl_s;
   logic             sda_s;
   logic [9:0]       sw_cnt;     // Switching period counter.
   logic             sw_tick;    // One-cycle pulse per period.
   logic             hit_seen;   // Latch threshold seen this cycle.
   logic [2:0]       hit_run;    // Consecutive cycles over latch.
   logic             cyc_block;  // Switching held off this cycle.
   logic [22:0]      tsat_cnt;   // Saturation duration counter.
   logic             ledg_trip;
   logic [5:0]       flags_reg;  // Sticky fault flags.
   logic [5:0]       flags_next;
   logic [5:0]       flag_set;
   logic             rd_clear;
   bld_state_t       state_reg;
   logic [7:0]       ptr_reg;    // Register index for the frame.
   logic             ack_reg;
   logic             rd_mode;
   logic [7:0]       tx_data;
   logic             start_p;
   logic             stop_p;
   logic             rx_valid;
   logic [7:0]       rx_byte;
   logic             tx_load;
   logic             drive_low;

   // Switching period in system clocks for a frequency code.
   function automatic logic [9:0] sw_period(input logic [1:0] code);
      case (code)
         2'h0:    sw_period = 10'(`BLD_SW0_CYC);
         2'h1:    sw_period = 10'(`BLD_SW1_CYC);
         2'h2:    sw_period = 10'(`BLD_SW2_CYC);
         default: sw_period = 10'(`BLD_SW3_CYC);
      endcase
   endfunction

   // Read multiplexer; unmapped indexes read as zero.
   function automatic logic [7:0] rd_mux(input logic [7:0] idx);
      case (idx)
         `BLD_ADR_DIM:   rd_mux = dim_cfg;
         `BLD_ADR_CHAN:  rd_mux = chan_cfg;
         `BLD_ADR_PROT:  rd_mux = {short_all_strings_enable,
                                   loop_saturation_time_select,
                                   flags_reg};
         `BLD_ADR_IDENT: rd_mux = IDENTITY_BYTE;
         default:        rd_mux = 8'h00;
      endcase
   endfunction

   // Reset is asserted at once and released through two stages.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign pin_raw = {current_limit_hit, current_latch_hit,
                     temp_decrement_hit, temp_upper_hit,
                     temp_lower_below, comp_saturated,
                     string_open_event, string_short_event,
                     output_uv_event};

   // Every pin input passes two flip-flops before use.
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_meta[gi] <= 1'b0;
               pin_s[gi]    <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_s[gi]    <= pin_meta[gi];
            end
         end
      end
   endgenerate

   // Bus lines idle high, so their synchronisers reset high.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_meta <= 1'b1;
         sda_meta <= 1'b1;
         scl_s    <= 1'b1;
         sda_s    <= 1'b1;
      end else begin
         scl_meta <= scl_i;
         sda_meta <= sda_i;
         scl_s    <= scl_meta;
         sda_s    <= sda_meta;
      end
   end

   // Switching clock divider; a new code applies to the running period at once.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_cnt  <= 10'h000;
         sw_tick <= 1'b0;
      end else if (sw_cnt >= sw_period(chan_cfg.switch_frequency_set_pin_select)
                            - 10'h001) begin
         sw_cnt  <= 10'h000;
         sw_tick <= 1'b1;
      end else begin
         sw_cnt  <= sw_cnt + 10'h001;
         sw_tick <= 1'b0;
      end
   end

   // Cycle-by-cycle limit: hold off, the next tick releases.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_block <= 1'b0;
      end else if (sw_tick) begin
         cyc_block <= 1'b0;
      end else if (pin_s[8]) begin
         cyc_block <= 1'b1;
      end
   end

   // Latch-off counter over whole switching cycles; a clean
   // cycle restarts the count, so only a run of five trips it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_seen    <= 1'b0;
         hit_run     <= 3'h0;
         latched_off <= 1'b0;
      end else begin
         if (sw_tick) begin
            hit_seen <= 1'b0;
            if (hit_seen || pin_s[7]) begin
               if (hit_run + 3'h1 == `BLD_LATCH_CYCLES) begin
                  latched_off <= 1'b1;
               end
               hit_run <= hit_run + 3'h1;
            end else begin
               hit_run <= 3'h0;
            end
         end else if (pin_s[7]) begin
            hit_seen <= 1'b1;
         end
         if (ledg_trip) begin
            latched_off <= 1'b1;
         end
      end
   end

   // Thermal shutdown with hysteresis between two comparators.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thermal_shutdown <= 1'b0;
      end else if (pin_s[5]) begin
         thermal_shutdown <= 1'b1;
      end else if (pin_s[4]) begin
         thermal_shutdown <= 1'b0;
      end
   end

   // Current decrement follows the 140C comparator when enabled.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         current_decrement <= 1'b0;
      end else begin
         current_decrement <= pin_s[6] &
            dim_cfg.overtemp_decrement_enable;
      end
   end

   // Switch gate and the start-of-cycle strobe for the modulator.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         switch_enable <= 1'b0;
         cycle_start   <= 1'b0;
      end else begin
         switch_enable <= ~cyc_block & ~latched_off &
                          ~thermal_shutdown & ~pin_s[8];
         cycle_start   <= sw_tick;
      end
   end

   // Pin-to-ground timer: saturation must last unbroken.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tsat_cnt <= 23'h000000;
      end else if (!pin_s[3]) begin
         tsat_cnt <= 23'h000000;
      end else if (!ledg_trip) begin
         tsat_cnt <= tsat_cnt + 23'h000001;
      end
   end

   always_comb begin
      if (loop_saturation_time_select) begin
         ledg_trip = pin_s[3] &&
            (tsat_cnt == 23'(TSAT_LONG_CYC - 1));
      end else begin
         ledg_trip = pin_s[3] &&
            (tsat_cnt == 23'(TSAT_SHORT_CYC - 1));
      end
   end

   // Fault events; over-temperature and overcurrent mark entry.
   always_comb begin
      flag_set = 6'h00;
      flag_set[`BLD_FLAG_LEDG] = ledg_trip;
      flag_set[`BLD_FLAG_OTP]  = pin_s[5] & ~thermal_shutdown;
      flag_set[`BLD_FLAG_UVP]  = pin_s[0];
      flag_set[`BLD_FLAG_OCP]  = sw_tick & ~latched_off &
         (hit_seen | pin_s[7]) &
         (hit_run + 3'h1 == `BLD_LATCH_CYCLES);
      flag_set[`BLD_FLAG_LEDS] = pin_s[1];
      flag_set[`BLD_FLAG_LEDO] = pin_s[2];
   end

   // A read of the fault register clears; a same-cycle event wins.
   assign rd_clear   = tx_load && (ptr_reg == `BLD_ADR_PROT);
   assign flags_next = (flags_reg & ~{6{rd_clear}}) | flag_set;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= `BLD_RST_FLAGS;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Bit-level engine of the serial port.
   bld_i2c_bits u_bits (
      .clk       (clk),
      .rst_n     (rst_n),
      .scl_s     (scl_s),
      .sda_s     (sda_s),
      .ack_want  (ack_reg),
      .rd_mode   (rd_mode),
      .tx_data   (tx_data),
      .start_p   (start_p),
      .stop_p    (stop_p),
      .rx_valid  (rx_valid),
      .rx_byte   (rx_byte),
      .tx_load   (tx_load),
      .drive_low (drive_low)
   );

   // Live read data, so a flag set just before the load is seen.
   always_comb begin
      tx_data = rd_mux(ptr_reg);
   end

   assign rd_mode = (state_reg == BLD_ST_READ);

   // Byte-level transaction sequencing.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= BLD_ST_IDLE;
         ack_reg   <= 1'b0;
         ptr_reg   <= 8'h00;
      end else if (stop_p) begin
         state_reg <= BLD_ST_IDLE;
         ack_reg   <= 1'b0;
      end else if (start_p) begin
         // Repeated start keeps the index for a following read.
         state_reg <= BLD_ST_ADDR;
         ack_reg   <= 1'b0;
      end else if (rx_valid) begin
         case (state_reg)
            BLD_ST_ADDR: begin
               if (rx_byte[7:1] == `BLD_DEV_ADDR) begin
                  ack_reg <= 1'b1;
                  if (rx_byte[0]) begin
                     state_reg <= BLD_ST_READ;
                  end else begin
                     state_reg <= BLD_ST_REG;
                  end
               end else begin
                  ack_reg   <= 1'b0;
                  state_reg <= BLD_ST_IDLE;
               end
            end
            BLD_ST_REG: begin
               ptr_reg   <= rx_byte;
               state_reg <= BLD_ST_DATA;
            end
            BLD_ST_DATA: begin
               state_reg <= BLD_ST_DATA;
            end
            default: begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   // Writable registers; identity and flags are not writable.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dim_cfg  <= `BLD_RST_DIM;
         chan_cfg <= `BLD_RST_CHAN;
         short_all_strings_enable    <= 1'b0;
         loop_saturation_time_select <= 1'b0;
      end else if (rx_valid && state_reg == BLD_ST_DATA) begin
         case (ptr_reg)
            `BLD_ADR_DIM: begin
               dim_cfg <= rx_byte;
            end
            `BLD_ADR_CHAN: begin
               chan_cfg <= rx_byte;
            end
            `BLD_ADR_PROT: begin
               short_all_strings_enable <=
                  rx_byte[`BLD_PROT_SEN_BIT];
               loop_saturation_time_select <=
                  rx_byte[`BLD_PROT_TSAT_BIT];
            end
            default: begin
               // Identity and unmapped indexes drop the byte.
               dim_cfg <= dim_cfg;
            end
         endcase
      end
   end

   // Open-drain data pin: output is always low, enable is active low.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_o    <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         sda_o    <= 1'b0;
         sda_oe_n <= ~drive_low;
      end
   end

endmodule

// >>> bld_regs.svh
`ifndef BLD_REGS_SVH
`define BLD_REGS_SVH

// Seven-bit bus address the device answers to.
`define BLD_DEV_ADDR      7'h38

// Register indexes.
`define BLD_ADR_DIM       8'h00
`define BLD_ADR_CHAN      8'h01
`define BLD_ADR_PROT      8'h02
`define BLD_ADR_IDENT     8'h03

// Reset values of the writable registers and the fault flags.
`define BLD_RST_DIM       8'h86
`define BLD_RST_CHAN      8'h28
`define BLD_RST_PROT      2'h0
`define BLD_RST_FLAGS     6'h00

// Field positions in the protection and fault register.
`define BLD_PROT_SEN_BIT  7
`define BLD_PROT_TSAT_BIT 6
`define BLD_FLAG_LEDG     5
`define BLD_FLAG_OTP      4
`define BLD_FLAG_UVP      3
`define BLD_FLAG_OCP      2
`define BLD_FLAG_LEDS     1
`define BLD_FLAG_LEDO     0

// System clock and switching periods.
`define BLD_CLK_KHZ       200000
`define BLD_SW0_KHZ       200
`define BLD_SW1_KHZ       400
`define BLD_SW2_KHZ       1000
`define BLD_SW3_KHZ       2200
`define BLD_SW0_CYC       (`BLD_CLK_KHZ / `BLD_SW0_KHZ)
`define BLD_SW1_CYC       (`BLD_CLK_KHZ / `BLD_SW1_KHZ)
`define BLD_SW2_CYC       (`BLD_CLK_KHZ / `BLD_SW2_KHZ)
`define BLD_SW3_CYC       (`BLD_CLK_KHZ / `BLD_SW3_KHZ)

// Consecutive over-threshold cycles before latch-off.
`define BLD_LATCH_CYCLES  3'h5

// Saturation times for the pin-to-ground detection.
`define BLD_TSAT_SHORT_MS 20
`define BLD_TSAT_LONG_MS  40
`define BLD_TSAT_SHORT_CYC (`BLD_TSAT_SHORT_MS * `BLD_CLK_KHZ)
`define BLD_TSAT_LONG_CYC  (`BLD_TSAT_LONG_MS * `BLD_CLK_KHZ)

`endif

// >>> bld_pkg.sv
package bld_pkg;

   // Dimming mode codes.
   typedef enum logic [1:0] {
      BLD_DIM_MIX    = 2'h0,
      BLD_DIM_PWM    = 2'h1,
      BLD_DIM_ANALOG = 2'h2,
      BLD_DIM_RSVD   = 2'h3
   } bld_dim_t;

   // Register 0x00 laid out bit for bit.
   typedef struct packed {
      logic       overtemp_decrement_enable;
      bld_dim_t   dim_mode;
      logic       mix_transfer_point_select;
      logic       mix_output_frequency_set_pin_select;
      logic [1:0] spread_modulation_frequency_set_pin;
      logic       spread_jitter_range;
   } bld_dim_cfg_t;

   // Register 0x01 laid out bit for bit.
   typedef struct packed {
      logic       phase_shift_enable;
      logic [1:0] short_threshold_select;
      logic [1:0] switch_frequency_set_pin_select;
      logic [2:0] active_string_count;
   } bld_chan_cfg_t;

   // Byte-level transaction states.
   typedef enum logic [2:0] {
      BLD_ST_IDLE = 3'b000,
      BLD_ST_ADDR = 3'b001,
      BLD_ST_REG  = 3'b010,
      BLD_ST_DATA = 3'b011,
      BLD_ST_READ = 3'b100
   } bld_state_t;

endpackage

// >>> bld_i2c_bits.sv
// Bit engine of the serial slave: start and stop detection, byte
// shifting, acknowledge drive and read-data shifting.
module bld_i2c_bits
   import bld_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Synchronised bus lines.
   input  wire logic       scl_s,
   input  wire logic       sda_s,
   // Byte-level control from the transaction logic.
   input  wire logic       ack_want,
   input  wire logic       rd_mode,
   input  wire logic [7:0] tx_data,
   // Events and data towards the transaction logic.
   output logic            start_p,
   output logic            stop_p,
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   output logic            tx_load,
   output logic            drive_low
);

   logic       scl_q;   // Clock line one cycle back.
   logic       sda_q;   // Data line one cycle back.
   logic [3:0] bit_cnt; // Bits seen in the current byte.
   logic       tx_on;   // Device is shifting a read byte out.
   logic       mack;    // Master acknowledged the last read byte.
   logic       rise;
   logic       fall;
   logic       start_c;
   logic       stop_c;

   assign rise    = scl_s & ~scl_q;
   assign fall    = ~scl_s & scl_q;
   assign start_c = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_c  = scl_s & scl_q & ~sda_q & sda_s;

   // Edge history of both lines.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // Event pulses, registered so the caller sees clean strobes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_p  <= 1'b0;
         stop_p   <= 1'b0;
         rx_valid <= 1'b0;
      end else begin
         start_p  <= start_c;
         stop_p   <= stop_c;
         rx_valid <= rise & (bit_cnt == 4'h7) & ~tx_on;
      end
   end

   // Shift register, bit counter and the line drive.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt   <= 4'h0;
         rx_byte   <= 8'h00;
         tx_on     <= 1'b0;
         mack      <= 1'b0;
         drive_low <= 1'b0;
         tx_load   <= 1'b0;
      end else begin
         tx_load <= 1'b0;
         if (start_c || stop_c) begin
            // A frame edge always frees the line.
            bit_cnt   <= 4'h0;
            tx_on     <= 1'b0;
            drive_low <= 1'b0;
         end else if (rise) begin
            if (bit_cnt < 4'h8) begin
               rx_byte <= {rx_byte[6:0], sda_s};
            end else begin
               mack <= ~sda_s;
            end
            if (bit_cnt != 4'h9) begin
               bit_cnt <= bit_cnt + 4'h1;
            end
         end else if (fall) begin
            if (bit_cnt == 4'h8) begin
               // Acknowledge slot: drive only for received bytes.
               drive_low <= ack_want & ~tx_on;
            end else if (bit_cnt == 4'h9) begin
               bit_cnt <= 4'h0;
               if (rd_mode && (!tx_on || mack)) begin
                  tx_on     <= 1'b1;
                  tx_load   <= 1'b1;
                  rx_byte   <= tx_data;
                  drive_low <= ~tx_data[7];
               end else begin
                  tx_on     <= 1'b0;
                  drive_low <= 1'b0;
               end
            end else if (tx_on) begin
               drive_low <= ~rx_byte[7];
            end
         end
      end
   end

endmodule

// >>> bld_regs_monitor.sv
module bld_regs_monitor
   import bld_pkg::*;
(
   // Clock, reset, bus clock and data line enable.
   input wire logic         clk,
   input wire logic         nrst,
   input wire logic         scl_i,
   input wire logic         sda_oe_n,
   // Sensor inputs.
   input wire logic         current_limit_hit,
   input wire logic         temp_decrement_hit,
   input wire logic         temp_upper_hit,
   input wire logic         temp_lower_below,
   // Configuration and state outputs.
   input wire bld_dim_cfg_t dim_cfg,
   input wire logic         switch_enable,
   input wire logic         cycle_start,
   input wire logic         current_decrement,
   input wire logic         thermal_shutdown,
   input wire logic         latched_off
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Input syncs cost a few cycles, so the bound has slack.
   property p_lim;
      $rose(current_limit_hit) |-> ##[1:8] !switch_enable;
   endproperty
   a_lim: assert property (p_lim)
      else $error("limit did not stop switching");
   property p_pulse;
      cycle_start |=> !cycle_start;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("cycle start wider than one cycle");
   property p_latch;
      latched_off |=> latched_off;
   endproperty
   a_latch: assert property (p_latch)
      else $error("latch-off released");
   property p_loff;
      latched_off |=> !switch_enable;
   endproperty
   a_loff: assert property (p_loff)
      else $error("switching while latched off");
   property p_decr;
      (temp_decrement_hit && dim_cfg.overtemp_decrement_enable)[*6]
         |-> current_decrement;
   endproperty
   a_decr: assert property (p_decr)
      else $error("no current decrement when hot");
   property p_nodecr;
      (!dim_cfg.overtemp_decrement_enable)[*2] |-> !current_decrement;
   endproperty
   a_nodecr: assert property (p_nodecr)
      else $error("decrement while disabled");
   property p_tsd;
      temp_upper_hit[*6] |-> thermal_shutdown;
   endproperty
   a_tsd: assert property (p_tsd)
      else $error("no shutdown when hot");
   property p_hold;
      (thermal_shutdown && !temp_lower_below)[*6] |=> thermal_shutdown;
   endproperty
   a_hold: assert property (p_hold)
      else $error("recovered above lower threshold");
   // The answer may only start pulling the line low while the bus clock is low.
   property p_ack;
      $fell(sda_oe_n) |-> !scl_i;
   endproperty
   a_ack: assert property (p_ack)
      else $error("data line moved with bus clock high");
endmodule

bind bld_config_regs bld_regs_monitor bld_regs_monitor_i (
   .clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_oe_n(sda_oe_n),
   .current_limit_hit(current_limit_hit),
   .temp_decrement_hit(temp_decrement_hit),
   .temp_upper_hit(temp_upper_hit), .temp_lower_below(temp_lower_below),
   .dim_cfg(dim_cfg), .switch_enable(switch_enable),
   .cycle_start(cycle_start), .current_decrement(current_decrement),
   .thermal_shutdown(thermal_shutdown), .latched_off(latched_off));

// >>> bld_i2c_master.sv
module bld_i2c_master (
   // Pacing clock.
   input  wire logic clk,
   // Bus lines; sda_m high means released.
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Data moves three cycles after the clock so no false start is seen.
   task automatic step(input logic s, input logic dt);
      scl = s;
      repeat (3) @(negedge clk);
      sda_m = dt;
      repeat (8) @(negedge clk);
   endtask
   task automatic start;
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop;
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   // Eight bits, MSB first, then a released ninth bit.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      logic [8:0] sh;
      sh = {tx, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, sh[i]);
         step(1'b1, sh[i]);
         sh[i] = sda;
      end
      rx = sh[8:1];
      step(1'b0, 1'b1);
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] a, dt);
      logic [7:0] x;
      start;
      xfer({dev, 1'b0}, x);
      xfer(a, x);
      xfer(dt, x);
      stop;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] dt);
      logic [7:0] x;
      start;
      xfer(8'h70, x);
      xfer(a, x);
      start;
      xfer(8'h71, x);
      xfer(8'hff, dt);
      stop;
   endtask
endmodule

// >>> bld_tb.sv
module tb
   import bld_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value.
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   logic          scl, sda_m, sda_o, sda_oe_n;
   logic          lim, lat, tdec, tup, tlow, csat, sopen, sshort, uv;
   bld_dim_cfg_t  dim_cfg;
   bld_chan_cfg_t chan_cfg;
   logic          sae, lst, sw_en, cyc_st, decr, tsd, loff;
   wire logic     sda;
   int            miscompares = 0;
   int            cmp_count = 0;
   logic [7:0]    d;
   logic [7:0]    vals [4] = '{8'h00, 8'h35, 8'hca, 8'hff};
   // Pull-up: the line is high unless someone pulls it low.
   assign sda = sda_m & (sda_oe_n | sda_o);
   always #2.5 clk = ~clk;
   bld_config_regs #(.TSAT_SHORT_CYC(50), .TSAT_LONG_CYC(100),
      .IDENTITY_BYTE(ID)) bld_config_regs_i (.clk(clk), .nrst(nrst),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .current_limit_hit(lim), .current_latch_hit(lat),
      .temp_decrement_hit(tdec), .temp_upper_hit(tup),
      .temp_lower_below(tlow), .comp_saturated(csat),
      .string_open_event(sopen), .string_short_event(sshort),
      .output_uv_event(uv), .dim_cfg(dim_cfg), .chan_cfg(chan_cfg),
      .short_all_strings_enable(sae), .loop_saturation_time_select(lst),
      .switch_enable(sw_en), .cycle_start(cyc_st),
      .current_decrement(decr), .thermal_shutdown(tsd),
      .latched_off(loff));
   bld_i2c_master bld_i2c_master_i (.clk(clk), .scl(scl),
      .sda_m(sda_m), .sda(sda));
   task automatic chk8(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, exp);
      bld_i2c_master_i.rd(a, d);
      chk8(d, exp);
   endtask
   task automatic wr(input logic [7:0] a, dt);
      bld_i2c_master_i.wr(7'h38, a, dt);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // A full run needs about 29000 cycles.
   initial begin
      repeat (80000) @(posedge clk);
      miscompares++;
      $display("ERROR %0t watchdog expired", $time);
      tally_and_finish;
   end
   initial begin
      {lim, lat, tdec, tup, tlow, csat, sopen, sshort, uv} = '0;
      cyc(5);
      nrst = 1'b1;
      cyc(10);
      rdc(8'h00, 8'h86);
      rdc(8'h01, 8'h28);
      rdc(8'h02, 8'h00);
      rdc(8'h03, ID);
      $display("test reset done");
      // Every mode, frequency and threshold code goes through both ways.
      foreach (vals[i]) begin
         wr(8'h00, vals[i]);
         wr(8'h01, vals[i]);
         rdc(8'h00, vals[i]);
         rdc(8'h01, vals[i]);
         chk8(dim_cfg, vals[i]);
         chk8(chan_cfg, vals[i]);
      end
      $display("test codes done");
      wr(8'h03, 8'h00);
      rdc(8'h03, ID);
      wr(8'h02, 8'hff);
      rdc(8'h02, 8'hc0);
      chk1(sae, 1'b1);
      chk1(lst, 1'b1);
      bld_i2c_master_i.wr(7'h39, 8'h00, 8'h11);
      rdc(8'h00, 8'hff);
      wr(8'h02, 8'h00);
      $display("test refusals done");
      {sopen, sshort, uv} = 3'h7;
      cyc(4);
      {sopen, sshort, uv} = 3'h0;
      rdc(8'h02, 8'h0b);
      rdc(8'h02, 8'h00);
      $display("test flags done");
      tdec = 1'b1;
      cyc(10);
      chk1(decr, 1'b1);
      wr(8'h00, 8'h7f);
      chk1(decr, 1'b0);
      tdec = 1'b0;
      tup = 1'b1;
      cyc(10);
      chk1(tsd, 1'b1);
      tup = 1'b0;
      cyc(10);
      chk1(tsd, 1'b1);
      tlow = 1'b1;
      cyc(10);
      chk1(tsd, 1'b0);
      tlow = 1'b0;
      rdc(8'h02, 8'h10);
      $display("test thermal done");
      // Switching period is 90 cycles at the fastest code set above.
      lim = 1'b1;
      cyc(8);
      chk1(sw_en, 1'b0);
      lim = 1'b0;
      cyc(200);
      chk1(sw_en, 1'b1);
      lat = 1'b1;
      cyc(200);
      chk1(loff, 1'b0);
      cyc(400);
      lat = 1'b0;
      cyc(10);
      chk1(loff, 1'b1);
      csat = 1'b1;
      cyc(80);
      csat = 1'b0;
      rdc(8'h02, 8'h24);
      $display("test current done");
      nrst = 1'b0;
      cyc(5);
      nrst = 1'b1;
      cyc(10);
      chk1(loff, 1'b0);
      rdc(8'h00, 8'h86);
      $display("test second reset done");
      tally_and_finish;
   end
endmodule
